//--- src/spwc_pkg.sv
// Notes on behaviour
// - In instant-off mode one press of the power button sends the system straight to off.
// - In delayed mode the system turns off only when the button is held longer than 4 seconds.
// - In delayed mode a press released before 4 seconds puts the system into suspend.
// - With restore policy Off the system stays down when mains power returns.
// - With restore policy On the system always starts when mains power returns.
// - With restore policy Auto the last on/off state is kept and restored when power returns.
// - With modem wake enabled an active ring indicator wakes the system from soft-off.
// - With alarm wake enabled the clock alarm wakes the system from suspend.
// - With LAN wake enabled a network wake request wakes the system.
// - With port wake on, parallel or serial activity or its interrupt line wakes the system.
// - With disk wake on, hard disk or floppy activity wakes the system.
// - With video wake enabled, video adapter activity brings the system back on.
package spwc_pkg;

  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned HOLD_SEC       = 4;
  localparam int unsigned HOLD_CYC       = HOLD_SEC * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W          = 27;
  localparam int unsigned NWAKE          = 6;

  // wake source bit positions
  localparam int unsigned WK_VIDEO = 0;
  localparam int unsigned WK_PORT  = 1;
  localparam int unsigned WK_DISK  = 2;
  localparam int unsigned WK_LAN   = 3;
  localparam int unsigned WK_RING  = 4;
  localparam int unsigned WK_ALARM = 5;

  typedef enum logic [1:0] {
    SPWC_RESTORE_OFF  = 2'h0,
    SPWC_RESTORE_ON   = 2'h1,
    SPWC_RESTORE_AUTO = 2'h2
  } spwc_restore_t;

  typedef enum logic [1:0] {
    SPWC_PWR_OFF,
    SPWC_PWR_ON,
    SPWC_PWR_SUSPEND
  } spwc_pwr_t;

  typedef struct packed {
    logic          delay_mode;
    spwc_restore_t restore;
    logic [5:0]    wake_en;
  } spwc_cfg_t;

endpackage : spwc_pkg

//--- src/spwc_debounce.sv
`timescale 1ns/10ps
module spwc_debounce
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic raw_in,
  output logic      clean_r
);
  import spwc_pkg::*;

  logic                meta_r;
  logic                sync_r;
  logic [CNT_W-1:0]    cnt_r;
  logic                stable;

  assign stable = (cnt_r == CNT_W'(DEBOUNCE_CYC - 1));

  // two-flop synchroniser, then a stability counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r  <= 1'b0;
      sync_r  <= 1'b0;
      cnt_r   <= '0;
      clean_r <= 1'b0;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      if (sync_r == clean_r)
        cnt_r <= '0;
      else if (stable)
      begin
        cnt_r   <= '0;
        clean_r <= sync_r;
      end
      else
        cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  chk_clean_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(clean_r) |-> $past(sync_r) == clean_r)
    else $error("debounced output took a value the input did not hold");

endmodule : spwc_debounce

//--- src/spwc_ctrl.sv
`timescale 1ns/10ps
module spwc_ctrl
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              soft_power_button_input,
  input  wire logic              mains_ok,
  input  wire spwc_pkg::spwc_cfg_t cfg,
  input  wire logic              video_act,
  input  wire logic              port_act,
  input  wire logic              port_irq,
  input  wire logic              disk_act,
  input  wire logic              lan_wake_req,
  input  wire logic              ring_ind,
  input  wire logic              rtc_alarm,
  output logic                   power_on_r,
  output logic                   suspend_r,
  output spwc_pkg::spwc_pwr_t    pwr_state
);
  import spwc_pkg::*;

  spwc_pwr_t          state_r;
  spwc_pwr_t          state_nxt;
  logic               btn_clean;
  logic               btn_prev_r;
  logic [CNT_W-1:0]   hold_r;
  logic               hold_done_r;
  logic               mains_prev_r;
  logic               was_on_r;
  logic [NWAKE-1:0]   wake_raw;
  logic [NWAKE-1:0]   wake_g;
  logic               wake_any;
  logic               alarm_wake;
  logic               ring_wake;
  logic               btn_rise;
  logic               btn_fall;
  logic               hold_hit;
  logic               mains_back;
  logic               restore_start;

  spwc_debounce u_deb (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .raw_in  (soft_power_button_input),
    .clean_r (btn_clean)
  );

  assign wake_raw[WK_VIDEO] = video_act;
  assign wake_raw[WK_PORT]  = port_act | port_irq;
  assign wake_raw[WK_DISK]  = disk_act;
  assign wake_raw[WK_LAN]   = lan_wake_req;
  assign wake_raw[WK_RING]  = ring_ind;
  assign wake_raw[WK_ALARM] = rtc_alarm;

  genvar gi;
  generate
    for (gi = 0; gi < NWAKE; gi++)
    begin : g_gate
      assign wake_g[gi] = wake_raw[gi] & cfg.wake_en[gi];
    end
  endgenerate

  // alarm only leaves suspend, ring only leaves soft-off
  assign alarm_wake = wake_g[WK_ALARM] & (state_r == SPWC_PWR_SUSPEND);
  assign ring_wake  = wake_g[WK_RING] & (state_r == SPWC_PWR_OFF);
  assign wake_any   = wake_g[WK_VIDEO] | wake_g[WK_PORT] | wake_g[WK_DISK]
                    | wake_g[WK_LAN] | alarm_wake | ring_wake;

  assign btn_rise   = btn_clean & ~btn_prev_r;
  assign btn_fall   = ~btn_clean & btn_prev_r;
  assign hold_hit   = btn_clean & (hold_r == CNT_W'(HOLD_CYC));
  assign mains_back = mains_ok & ~mains_prev_r;
  assign restore_start = (cfg.restore == SPWC_RESTORE_ON)
                       | ((cfg.restore == SPWC_RESTORE_AUTO) & was_on_r);

  always_comb
  begin
    state_nxt = state_r;
    if (!mains_ok)
      state_nxt = SPWC_PWR_OFF;
    else if (mains_back)
      state_nxt = restore_start ? SPWC_PWR_ON : SPWC_PWR_OFF;
    else
      case (state_r)
        SPWC_PWR_ON:
        begin
          if (!cfg.delay_mode && btn_rise)
            state_nxt = SPWC_PWR_OFF;
          else if (cfg.delay_mode && hold_hit && !hold_done_r)
            state_nxt = SPWC_PWR_OFF;
          else if (cfg.delay_mode && btn_fall && !hold_done_r)
            state_nxt = SPWC_PWR_SUSPEND;
        end
        SPWC_PWR_OFF,
        SPWC_PWR_SUSPEND:
        begin
          // press that turned us off must be released before it can wake
          if ((btn_rise && !hold_done_r) || wake_any)
            state_nxt = SPWC_PWR_ON;
        end
        default: state_nxt = SPWC_PWR_OFF;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= SPWC_PWR_OFF;
      btn_prev_r   <= 1'b0;
      mains_prev_r <= 1'b0;
      was_on_r     <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      btn_prev_r   <= btn_clean;
      mains_prev_r <= mains_ok;
      if (mains_ok)
        was_on_r <= (state_nxt == SPWC_PWR_ON);
    end
  end

  // hold timer runs while pressed; saturates at threshold
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_r      <= '0;
      hold_done_r <= 1'b0;
    end
    else if (!btn_clean)
    begin
      hold_r      <= '0;
      hold_done_r <= 1'b0;
    end
    else
    begin
      if (hold_r != CNT_W'(HOLD_CYC))
        hold_r <= hold_r + CNT_W'(1);
      if (hold_hit || (btn_rise && state_r != SPWC_PWR_ON))
        hold_done_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_on_r <= 1'b0;
      suspend_r  <= 1'b0;
    end
    else
    begin
      power_on_r <= (state_nxt == SPWC_PWR_ON);
      suspend_r  <= (state_nxt == SPWC_PWR_SUSPEND);
    end
  end

  assign pwr_state = state_r;

  sequence s_short_press;
    btn_fall && !hold_done_r;
  endsequence

  chk_instant_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == SPWC_PWR_ON && !cfg.delay_mode && btn_rise && mains_ok && !mains_back
    |=> state_r == SPWC_PWR_OFF)
    else $error("instant-off press did not power down");

  chk_long_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == SPWC_PWR_ON && cfg.delay_mode && $fell(state_r == SPWC_PWR_ON) == 1'b0
    && state_nxt == SPWC_PWR_OFF && mains_ok && !mains_back
    |-> hold_hit)
    else $error("delayed mode powered off without a full hold");

  chk_short_susp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == SPWC_PWR_ON && cfg.delay_mode && mains_ok && !mains_back
    ##0 s_short_press |=> state_r == SPWC_PWR_SUSPEND)
    else $error("short press did not suspend");

  chk_restore_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mains_back && cfg.restore == SPWC_RESTORE_OFF |=> state_r == SPWC_PWR_OFF)
    else $error("restore off still powered up");

  chk_restore_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mains_back && cfg.restore == SPWC_RESTORE_ON |=> power_on_r)
    else $error("restore on did not power up");

  chk_restore_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mains_back && cfg.restore == SPWC_RESTORE_AUTO
    |=> (state_r == SPWC_PWR_ON) == $past(was_on_r))
    else $error("auto restore ignored previous state");

  chk_ring_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == SPWC_PWR_OFF && ring_ind && cfg.wake_en[WK_RING] && mains_ok && !mains_back
    |=> state_r == SPWC_PWR_ON)
    else $error("ring indicator did not wake from off");

  chk_alarm_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == SPWC_PWR_SUSPEND && rtc_alarm && cfg.wake_en[WK_ALARM] && mains_ok
    && !mains_back
    |=> state_r == SPWC_PWR_ON)
    else $error("alarm did not wake from suspend");

  chk_lan_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    // mains return takes precedence over any wake in the same cycle
    state_r != SPWC_PWR_ON && lan_wake_req && cfg.wake_en[WK_LAN] && mains_ok
    && !mains_back
    |=> state_r == SPWC_PWR_ON)
    else $error("lan wake ignored");

  chk_gated_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != SPWC_PWR_ON && !btn_rise && wake_g == '0 && !mains_back
    |=> state_r != SPWC_PWR_ON)
    else $error("power came on with no enabled wake source");

  chk_video_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != SPWC_PWR_ON && (video_act | port_act | port_irq | disk_act)
    && (cfg.wake_en[WK_VIDEO] & video_act | cfg.wake_en[WK_PORT] & (port_act | port_irq)
    | cfg.wake_en[WK_DISK] & disk_act) && mains_ok && !mains_back
    |=> power_on_r)
    else $error("device activity wake ignored");

endmodule : spwc_ctrl

//--- tb/spwc_far_model.sv
`timescale 1ns/10ps
module spwc_far_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] req,
  input  wire logic       slow,
  input  wire logic       btn_req,
  input  wire logic       mains_req,
  output logic [6:0]      act,
  output logic            button,
  output logic            mains
);
  logic [6:0] stage1_r;
  logic [6:0] stage2_r;
  logic [6:0] stage3_r;
  // slow peripherals answer two cycles later than prompt ones
  assign act = slow ? stage3_r : stage1_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      button   <= 1'b0;
      mains    <= 1'b0;
    end
    else
    begin
      stage1_r <= req;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      button   <= btn_req;
      mains    <= mains_req;
    end
  end
endmodule : spwc_far_model

//--- tb/soft_power_and_wake_control_tb_top.sv
`timescale 1ns/10ps
module soft_power_and_wake_control_tb_top;
  import spwc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] req = '0;
  logic slow = 1'b0;
  logic btn_req = 1'b0;
  logic mains_req = 1'b1;
  logic [6:0] act;
  logic button;
  logic mains;
  spwc_cfg_t cfg = '0;
  logic power_on_r;
  logic suspend_r;
  spwc_pwr_t pwr_state;
  spwc_pwr_t last_st = SPWC_PWR_OFF;
  spwc_pwr_t cur = SPWC_PWR_OFF;
  spwc_pwr_t notes[$];
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] lf = 32'h4ca214cf;
  // request bit order: video, port, irq, disk, lan, ring, alarm
  int ebit[7] = '{WK_VIDEO, WK_PORT, WK_PORT, WK_DISK, WK_LAN, WK_RING, WK_ALARM};

  always #25 ref_clk = ~ref_clk;

  spwc_far_model far (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .slow(slow),
    .btn_req(btn_req), .mains_req(mains_req), .act(act), .button(button), .mains(mains));

  spwc_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .soft_power_button_input(button),
    .mains_ok(mains), .cfg(cfg), .video_act(act[0]), .port_act(act[1]), .port_irq(act[2]),
    .disk_act(act[3]), .lan_wake_req(act[4]), .ring_ind(act[5]), .rtc_alarm(act[6]),
    .power_on_r(power_on_r), .suspend_r(suspend_r), .pwr_state(pwr_state));

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check_st(spwc_pwr_t exp);
    samples_checked++;
    if (pwr_state !== exp || power_on_r !== (exp == SPWC_PWR_ON) ||
        suspend_r !== (exp == SPWC_PWR_SUSPEND))
    begin
      failures++;
      $display("[ERR] %0t power state differs from expected", $time);
    end
  endtask : check_st

  task automatic note(spwc_pwr_t s);
    notes.push_back(s);
    cur = s;
  endtask : note

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // no transition expected: state must still be the last noted one
  task automatic quiet();
    tick(12);
    // look between edges so the registered outputs have settled
    @(negedge ref_clk);
    check_st(cur);
    @(posedge ref_clk);
  endtask : quiet

  task automatic settle();
    for (int i = 0; i < 40 && notes.size() != 0; i++)
      @(posedge ref_clk);
    if (notes.size() != 0)
    begin
      failures++;
      $display("[ERR] %0t expected transition never came", $time);
      print_verdict();
    end
    else
      tick(4);
  endtask : settle

  task automatic pulse(int b);
    @(posedge ref_clk);
    req <= 7'h1 << b;
    @(posedge ref_clk);
    req <= '0;
  endtask : pulse

  task automatic set_mains(spwc_restore_t p, logic v);
    @(posedge ref_clk);
    cfg.restore <= p;
    mains_req   <= v;
  endtask : set_mains

  always @(negedge ref_clk)
  begin
    if (rst_n && pwr_state !== last_st)
    begin
      last_st = pwr_state;
      if (notes.size() == 0)
      begin
        failures++;
        $display("[ERR] %0t power state moved without cause", $time);
      end
      else
        check_st(notes.pop_front());
    end
  end

  initial
  begin
    tick(16);
    rst_n <= 1'b1;
    quiet();
    // short press far below the debounce time must be ignored
    btn_req <= 1'b1;
    tick(100);
    btn_req <= 1'b0;
    quiet();
    for (int i = 0; i < 7; i++)
    begin
      lf = lfsr_next(lf);
      cfg.wake_en <= lf[5:0] & ~(6'h1 << ebit[i]);
      slow <= lf[7];
      pulse(i);
      quiet();
      lf = lfsr_next(lf);
      cfg.wake_en <= lf[5:0] | (6'h1 << ebit[i]);
      // button mode must not change how wake sources act
      cfg.delay_mode <= lf[8];
      slow <= lf[7];
      if (i < 6)
      begin
        note(SPWC_PWR_ON);
        pulse(i);
        settle();
        note(SPWC_PWR_OFF);
        set_mains(SPWC_RESTORE_OFF, 1'b0);
        settle();
        set_mains(SPWC_RESTORE_OFF, 1'b1);
        quiet();
      end
      else
      begin
        pulse(i);
        quiet();
      end
    end
    set_mains(SPWC_RESTORE_ON, 1'b0);
    tick(5);
    note(SPWC_PWR_ON);
    set_mains(SPWC_RESTORE_ON, 1'b1);
    settle();
    note(SPWC_PWR_OFF);
    set_mains(SPWC_RESTORE_AUTO, 1'b0);
    settle();
    note(SPWC_PWR_ON);
    set_mains(SPWC_RESTORE_AUTO, 1'b1);
    settle();
    note(SPWC_PWR_OFF);
    set_mains(SPWC_RESTORE_OFF, 1'b0);
    settle();
    set_mains(SPWC_RESTORE_OFF, 1'b1);
    quiet();
    set_mains(SPWC_RESTORE_AUTO, 1'b0);
    tick(5);
    set_mains(SPWC_RESTORE_AUTO, 1'b1);
    quiet();
    print_verdict();
  end
endmodule : soft_power_and_wake_control_tb_top
